// *** design/bax_defines.vh ***
/*
 * constants for the byte alu slice: opcodes, special-function addresses,
 * reset values and memory size.
 * assumes the includer is the bax datapath and nothing redefines these names.
 */
`ifndef BAX_DEFINES_VH
`define BAX_DEFINES_VH

// full opcodes
`define BAX_OP_SUBB_IMM  8'h94
`define BAX_OP_SUBB_DIR  8'h95
`define BAX_OP_SWAP      8'hc4
`define BAX_OP_BYTEX_DIR 8'hc5
`define BAX_OP_XOR_DIR_A 8'h62
`define BAX_OP_XOR_DIR_I 8'h63
`define BAX_OP_XOR_A_IMM 8'h64
`define BAX_OP_XOR_A_DIR 8'h65

// opcode bits 7..1, bit 0 picks the pointer register
`define BAX_OP7_SUBB_IND 7'h4b
`define BAX_OP7_BYTEX_IND  7'h63
`define BAX_OP7_DIGITX_IND 7'h6b
`define BAX_OP7_XOR_IND  7'h33

// opcode bits 7..3, bits 2..0 pick the bank register
`define BAX_OP5_SUBB_REG 5'h13
`define BAX_OP5_BYTEX_REG 5'h19
`define BAX_OP5_XOR_REG  5'h0d

// direct address space
`define BAX_SFR_BASE     8'h80
`define BAX_SFR_ACC      8'he0
`define BAX_SFR_PORT     8'h90

// reset values
`define BAX_ACC_RST      8'h00
`define BAX_PORT_RST     8'hff
`define BAX_FLAG_RST     1'b0

// internal ram
`define BAX_RAM_DEPTH    128
`define BAX_RAM_AW       7

`endif

// *** design/bax_core.v ***
/*
 * byte alu slice: subtract with borrow, nibble rotate, byte exchange,
 * digit exchange and exclusive or, with operand addressing and the port
 * read-modify-write path. each instruction executes in one clock.
 * assumes the fetch stage presents opcode and operand bytes with a one-cycle
 * instr_valid strobe, and holds bank_sel steady while an instruction runs.
 */
`timescale 1ns/1ps
`include "bax_defines.vh"

module bax_core (
	clk_sys,
	resetn,
	instr_valid,
	opcode,
	operand1,
	operand2,
	bank_sel,
	port_pins,
	acc_q,
	cy_q,
	half_borrow_q,
	signed_range_q,
	port_latch_q,
	done_q,
	bad_op_q
);
	input  wire       clk_sys;      // core clock
	input  wire       resetn;       // synchronous, active low
	input  wire       instr_valid;  // one-cycle instruction strobe
	input  wire [7:0] opcode;       // instruction byte
	input  wire [7:0] operand1;     // first operand byte
	input  wire [7:0] operand2;     // second operand byte
	input  wire [1:0] bank_sel;     // register bank select
	input  wire [7:0] port_pins;    // external pin levels
	output reg  [7:0] acc_q;        // accumulator
	output reg        cy_q;         // carry / borrow flag
	output reg        half_borrow_q;  // half-borrow flag
	output reg        signed_range_q; // signed-range flag
	output reg  [7:0] port_latch_q; // output port data latch
	output reg        done_q;       // pulse: instruction retired
	output reg        bad_op_q;     // pulse: opcode not handled here

	// internal ram, bank registers live in its bottom 32 bytes
	reg [7:0] ram [0:`BAX_RAM_DEPTH-1];

	// decode results
	reg        is_subb;          // subtract group
	reg        is_swap;          // nibble rotate
	reg        is_bytex;         // byte exchange
	reg        is_digitx;        // digit exchange
	reg        is_xor_a;         // exclusive or into acc
	reg        is_xor_d;         // exclusive or into direct byte
	reg        src_imm;          // source is operand1 immediate
	reg        src_dir;          // source is a direct address
	reg        src_ind;          // source is ram through a pointer
	reg        src_reg;          // source is a bank register
	reg        known;            // opcode handled by this slice

	// addresses and operand values
	wire [`BAX_RAM_AW-1:0] reg_addr;  // bank register ram address
	wire [`BAX_RAM_AW-1:0] ptr_addr;  // pointer register ram address
	wire [7:0]             ptr_val;   // pointer contents
	wire [`BAX_RAM_AW-1:0] ind_addr;  // indirect target address
	reg  [7:0]             dir_rd;    // direct read, pins for the port
	reg  [7:0]             dir_rmw;   // direct read, latch for the port
	reg  [7:0]             src_val;   // selected source byte

	// subtract chain
	wire [8:0] brw;              // borrow into each bit, brw[0] is carry
	wire [7:0] diff;             // difference bits

	// next-state values
	reg                    ram_we;
	reg [`BAX_RAM_AW-1:0]  ram_wa;
	reg [7:0]              ram_wd;
	reg [7:0]              acc_d;
	reg                    cy_d;
	reg                    half_borrow_d;
	reg                    signed_range_d;
	reg [7:0]              port_d;
	reg [7:0]              dwr_val;  // value headed for a direct address
	reg [7:0]              dwr_addr; // direct address being written
	reg                    dwr_en;   // direct write requested

	// bank register: bank select picks one of four groups of eight
	assign reg_addr = {2'b00, bank_sel, opcode[2:0]};
	// pointer register is bank register zero or one
	assign ptr_addr = {2'b00, bank_sel, 2'b00, opcode[0]};
	assign ptr_val  = ram[ptr_addr];
	// only the lower 128 bytes exist; pointer bit seven is ignored
	assign ind_addr = ptr_val[`BAX_RAM_AW-1:0];

	// opcode decode, one group at a time
	always @* begin
		is_subb  = 1'b0;
		is_swap  = 1'b0;
		is_bytex  = 1'b0;
		is_digitx = 1'b0;
		is_xor_a = 1'b0;
		is_xor_d = 1'b0;
		src_imm  = 1'b0;
		src_dir  = 1'b0;
		src_ind  = 1'b0;
		src_reg  = 1'b0;
		if (opcode == `BAX_OP_SUBB_IMM) begin
			is_subb = 1'b1;
			src_imm = 1'b1;
		end else if (opcode == `BAX_OP_SUBB_DIR) begin
			is_subb = 1'b1;
			src_dir = 1'b1;
		end else if (opcode[7:1] == `BAX_OP7_SUBB_IND) begin
			is_subb = 1'b1;
			src_ind = 1'b1;
		end else if (opcode[7:3] == `BAX_OP5_SUBB_REG) begin
			is_subb = 1'b1;
			src_reg = 1'b1;
		end else if (opcode == `BAX_OP_SWAP) begin
			is_swap = 1'b1;
		end else if (opcode == `BAX_OP_BYTEX_DIR) begin
			is_bytex = 1'b1;
			src_dir  = 1'b1;
		end else if (opcode[7:1] == `BAX_OP7_BYTEX_IND) begin
			is_bytex = 1'b1;
			src_ind  = 1'b1;
		end else if (opcode[7:3] == `BAX_OP5_BYTEX_REG) begin
			is_bytex = 1'b1;
			src_reg  = 1'b1;
		end else if (opcode[7:1] == `BAX_OP7_DIGITX_IND) begin
			is_digitx = 1'b1;
			src_ind   = 1'b1;
		end else if (opcode == `BAX_OP_XOR_DIR_A) begin
			is_xor_d = 1'b1;
		end else if (opcode == `BAX_OP_XOR_DIR_I) begin
			is_xor_d = 1'b1;
		end else if (opcode == `BAX_OP_XOR_A_IMM) begin
			is_xor_a = 1'b1;
			src_imm  = 1'b1;
		end else if (opcode == `BAX_OP_XOR_A_DIR) begin
			is_xor_a = 1'b1;
			src_dir  = 1'b1;
		end else if (opcode[7:1] == `BAX_OP7_XOR_IND) begin
			is_xor_a = 1'b1;
			src_ind  = 1'b1;
		end else if (opcode[7:3] == `BAX_OP5_XOR_REG) begin
			is_xor_a = 1'b1;
			src_reg  = 1'b1;
		end
		known = is_subb | is_swap | is_bytex | is_digitx | is_xor_a | is_xor_d;
	end

	// direct space reads; plain reads see the pins, modify reads the latch
	always @* begin
		if (operand1 < `BAX_SFR_BASE) begin
			dir_rd  = ram[operand1[`BAX_RAM_AW-1:0]];
			dir_rmw = dir_rd;
		end else if (operand1 == `BAX_SFR_ACC) begin
			dir_rd  = acc_q;
			dir_rmw = acc_q;
		end else if (operand1 == `BAX_SFR_PORT) begin
			dir_rd  = port_pins;
			dir_rmw = port_latch_q;
		end else begin
			// unimplemented special registers read as zero
			dir_rd  = 8'h00;
			dir_rmw = 8'h00;
		end
	end

	// source operand mux shared by subtract, exchange and exclusive or
	always @* begin
		if (src_imm) begin
			src_val = operand1;
		end else if (src_dir) begin
			src_val = dir_rd;
		end else if (src_ind) begin
			src_val = ram[ind_addr];
		end else if (src_reg) begin
			src_val = ram[reg_addr];
		end else begin
			src_val = 8'h00;
		end
	end

	// ripple borrow chain, one full subtractor per bit
	assign brw[0] = cy_q;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_sub
			assign diff[gi]    = acc_q[gi] ^ src_val[gi] ^ brw[gi];
			assign brw[gi + 1] = (~acc_q[gi] & src_val[gi]) |
			                     (~acc_q[gi] & brw[gi]) |
			                     (src_val[gi] & brw[gi]);
		end
	endgenerate

	// execute: work out every write of the instruction in one place
	always @* begin
		ram_we   = 1'b0;
		ram_wa   = {`BAX_RAM_AW{1'b0}};
		ram_wd   = 8'h00;
		acc_d    = acc_q;
		cy_d     = cy_q;
		half_borrow_d  = half_borrow_q;
		signed_range_d = signed_range_q;
		port_d   = port_latch_q;
		dwr_en   = 1'b0;
		dwr_addr = operand1;
		dwr_val  = 8'h00;
		if (instr_valid) begin
			if (is_subb) begin
				acc_d = diff;
				cy_d  = brw[8];
				half_borrow_d  = brw[4];
				signed_range_d = brw[7] ^ brw[8];
			end else if (is_swap) begin
				// flags fall through unchanged
				acc_d = {acc_q[3:0], acc_q[7:4]};
			end else if (is_bytex) begin
				// both writes land on the same edge, so the swap is atomic
				acc_d = src_val;
				if (src_dir) begin
					dwr_en  = 1'b1;
					dwr_val = acc_q;
				end else begin
					ram_we = 1'b1;
					ram_wa = src_ind ? ind_addr : reg_addr;
					ram_wd = acc_q;
				end
			end else if (is_digitx) begin
				acc_d  = {acc_q[7:4], src_val[3:0]};
				ram_we = 1'b1;
				ram_wa = ind_addr;
				ram_wd = {src_val[7:4], acc_q[3:0]};
			end else if (is_xor_a) begin
				acc_d = acc_q ^ src_val;
			end else if (is_xor_d) begin
				dwr_en = 1'b1;
				// mask is acc for 62, second operand byte for 63
				if (opcode[0]) begin
					dwr_val = dir_rmw ^ operand2;
				end else begin
					dwr_val = dir_rmw ^ acc_q;
				end
			end
			// route a direct write; acc target overrides the acc result
			if (dwr_en) begin
				if (dwr_addr < `BAX_SFR_BASE) begin
					ram_we = 1'b1;
					ram_wa = dwr_addr[`BAX_RAM_AW-1:0];
					ram_wd = dwr_val;
				end else if (dwr_addr == `BAX_SFR_ACC) begin
					acc_d = dwr_val;
				end else if (dwr_addr == `BAX_SFR_PORT) begin
					port_d = dwr_val;
				end
			end
		end
	end

	// architectural state; ram is data and is not cleared by reset
	always @(posedge clk_sys) begin
		if (!resetn) begin
			acc_q        <= `BAX_ACC_RST;
			cy_q         <= `BAX_FLAG_RST;
			half_borrow_q  <= `BAX_FLAG_RST;
			signed_range_q <= `BAX_FLAG_RST;
			port_latch_q <= `BAX_PORT_RST;
			done_q       <= 1'b0;
			bad_op_q     <= 1'b0;
		end else begin
			acc_q        <= acc_d;
			cy_q         <= cy_d;
			half_borrow_q  <= half_borrow_d;
			signed_range_q <= signed_range_d;
			port_latch_q <= port_d;
			done_q       <= instr_valid & known;
			bad_op_q     <= instr_valid & ~known;
		end
	end

	// single ram write port; no instruction here needs two writes
	always @(posedge clk_sys) begin
		if (resetn && ram_we) begin
			ram[ram_wa] <= ram_wd;
		end
	end

endmodule

// *** verification/bax_props.sv ***
/* assertion checker for the bax_core ports.
   assumes one clock domain; bound to every bax_core instance. */
`timescale 1ns/1ps
module bax_props (
	input wire       clk_sys,
	input wire       resetn,
	input wire       instr_valid,
	input wire [7:0] opcode,
	input wire [7:0] operand1,
	input wire [7:0] operand2,
	input wire [7:0] acc_q,
	input wire       cy_q,
	input wire       half_borrow_q,
	input wire       signed_range_q,
	input wire [7:0] port_latch_q,
	input wire       done_q,
	input wire       bad_op_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// borrow chain split at bits 3, 6 and 7
	wire [8:0] sub_full = {1'b0, acc_q} - {1'b0, operand1} - {8'h00, cy_q};
	wire [4:0] sub_low  = {1'b0, acc_q[3:0]} - {1'b0, operand1[3:0]} - {4'h0, cy_q};
	wire [7:0] sub_six  = {1'b0, acc_q[6:0]} - {1'b0, operand1[6:0]} - {7'h00, cy_q};
	// instruction taken at this edge
	sequence s_take(op);
		instr_valid && opcode == op;
	endsequence
	a_subb_result: assert property (s_take(8'h94) |=> {cy_q, acc_q} == $past(sub_full))
		else $error("subtract result or carry wrong");
	a_half_borrow: assert property (s_take(8'h94) |=> half_borrow_q == $past(sub_low[4]))
		else $error("half borrow flag wrong");
	a_signed_range: assert property (s_take(8'h94) |=>
		signed_range_q == $past(sub_full[8] ^ sub_six[7]))
		else $error("signed range flag wrong");
	a_nibble_swap: assert property (s_take(8'hc4) |=> acc_q == {$past(acc_q[3:0]), $past(acc_q[7:4])})
		else $error("nibble rotate wrong");
	a_flags_kept: assert property (instr_valid && opcode[7:4] != 4'h9 |=>
		$stable({cy_q, half_borrow_q, signed_range_q}))
		else $error("flags changed outside subtract");
	a_xor_imm: assert property (s_take(8'h64) |=> acc_q == $past(acc_q ^ operand1))
		else $error("exclusive or into acc wrong");
	a_port_rmw: assert property (s_take(8'h63) ##0 operand1 == 8'h90 |=>
		port_latch_q == $past(port_latch_q ^ operand2))
		else $error("port modify did not use latch");
	a_subb_decode: assert property (instr_valid && opcode[7:3] == 5'h13 |=> done_q && !bad_op_q)
		else $error("subtract opcode not retired");
	a_idle_quiet: assert property (!instr_valid |=> !done_q && !bad_op_q)
		else $error("retire pulse without instruction");
	a_reset_state: assert property (disable iff (1'b0) !resetn |=> acc_q == 8'h00 && port_latch_q == 8'hff && !cy_q && !done_q)
		else $error("reset values wrong");
endmodule
bind bax_core bax_props bax_props_inst (.clk_sys(clk_sys), .resetn(resetn),
	.instr_valid(instr_valid), .opcode(opcode), .operand1(operand1), .operand2(operand2),
	.acc_q(acc_q), .cy_q(cy_q), .half_borrow_q(half_borrow_q),
	.signed_range_q(signed_range_q), .port_latch_q(port_latch_q),
	.done_q(done_q), .bad_op_q(bad_op_q));

// *** verification/bax_core_bench.sv ***
/* self-checking bench for bax_core.
   assumes ram powers up unknown; bench tracks acc, latch and flags. */
`timescale 1ns/1ps
module bax_core_bench;
	logic       clk_sys = 1'b0;   // core clock
	logic       resetn = 1'b0;    // active low reset
	logic       instr_valid = 1'b0;
	logic [7:0] opcode = 8'h00;
	logic [7:0] operand1 = 8'h00;
	logic [7:0] operand2 = 8'h00;
	logic [1:0] bank_sel = 2'h0;
	logic [7:0] port_pins = 8'h00;
	wire  [7:0] acc_q;
	wire  [7:0] port_latch_q;
	wire        cy_q, half_borrow_q, signed_range_q, done_q, bad_op_q;
	logic [7:0] ea = 8'h00;       // expected acc
	logic [7:0] el = 8'hff;       // expected latch
	logic [2:0] ef = 3'h0;        // expected carry, half borrow, signed range
	int         error_cnt = 0;
	int         total_checks = 0;
	int         cyc = 0;
	always #5 clk_sys = ~clk_sys;
	bax_core bax_core_inst (.clk_sys(clk_sys), .resetn(resetn), .instr_valid(instr_valid),
		.opcode(opcode), .operand1(operand1), .operand2(operand2), .bank_sel(bank_sel),
		.port_pins(port_pins), .acc_q(acc_q), .cy_q(cy_q), .half_borrow_q(half_borrow_q),
		.signed_range_q(signed_range_q),
		.port_latch_q(port_latch_q), .done_q(done_q), .bad_op_q(bad_op_q));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// one instruction; caller sets expectations first
	task ex(input logic [7:0] op, input logic [7:0] a1, input logic [7:0] a2);
		@(negedge clk_sys);
		instr_valid = 1'b1;
		opcode = op;
		operand1 = a1;
		operand2 = a2;
		@(negedge clk_sys);
		instr_valid = 1'b0;
		chk({6'h00, done_q, bad_op_q}, 8'h02);
		chk(acc_q, ea);
		chk({5'h00, cy_q, half_borrow_q, signed_range_q}, {5'h00, ef});
		chk(port_latch_q, el);
	endtask
	// acc from pins via exchange with the port; latch gets old acc
	task ld(input logic [7:0] v);
		port_pins = v;
		el = ea;
		ea = v;
		ex(8'hc5, 8'h90, 8'h00);
	endtask
	// ram store by exchange; acc takes the old ram byte
	task st(input logic [7:0] adr, input logic [7:0] v, input logic [7:0] old);
		ld(v);
		ea = old;
		ex(8'hc5, adr, 8'h00);
	endtask
	// subtract with flags worked out per borrow group
	task sb(input logic [7:0] op, input logic [7:0] a1, input logic [7:0] s);
		logic [8:0] f;
		logic [4:0] lo;
		logic [7:0] six;
		f = {1'b0, ea} - {1'b0, s} - {8'h00, ef[2]};
		lo = {1'b0, ea[3:0]} - {1'b0, s[3:0]} - {4'h0, ef[2]};
		six = {1'b0, ea[6:0]} - {1'b0, s[6:0]} - {7'h00, ef[2]};
		ea = f[7:0];
		ef = {f[8], lo[4], f[8] ^ six[7]};
		ex(op, a1, 8'h00);
	endtask
	task t_subb;
		ld(8'h00);
		sb(8'h94, 8'h01, 8'h01);
		st(8'h02, 8'h54, 8'hxx);
		ld(8'hc9);
		sb(8'h9a, 8'h00, 8'h54);
		chk(acc_q, 8'h74);
		st(8'h30, 8'h7f, 8'hxx);
		ld(8'h80);
		sb(8'h95, 8'h30, 8'h7f);
		st(8'h01, 8'h30, 8'hxx);
		ld(8'h10);
		sb(8'h97, 8'h00, 8'h7f);
		$display("subtract test done");
	endtask
	task t_move;
		ld(8'hc5);
		ea = 8'h5c;
		ex(8'hc4, 8'h00, 8'h00);
		st(8'h00, 8'h20, 8'hxx);
		st(8'h20, 8'h75, 8'hxx);
		ld(8'h3f);
		ea = 8'h75;
		ex(8'hc6, 8'h00, 8'h00);
		ld(8'h36);
		ea = 8'h3f;
		ex(8'hd6, 8'h00, 8'h00);
		ea = 8'h36;
		ex(8'hc5, 8'h20, 8'h00);
		st(8'h0b, 8'ha5, 8'hxx);
		bank_sel = 2'h1;
		ld(8'h11);
		ea = 8'ha5;
		ex(8'hcb, 8'h00, 8'h00);
		bank_sel = 2'h0;
		$display("exchange test done");
	endtask
	task t_xor;
		st(8'h00, 8'haa, 8'h20);
		ld(8'hc3);
		ea = 8'h69;
		ex(8'h68, 8'h00, 8'h00);
		ea = 8'h66;
		ex(8'h64, 8'h0f, 8'h00);
		ea = 8'h19;
		ex(8'h65, 8'h30, 8'h00);
		ea = 8'h66;
		ex(8'h67, 8'h00, 8'h00);
		ex(8'h62, 8'h30, 8'h00);
		ea = 8'h7f;
		ex(8'h65, 8'h30, 8'h00);
		ld(8'h5a);
		port_pins = 8'hff;
		el = 8'h4e;
		ex(8'h63, 8'h90, 8'h31);
		el = 8'h14;
		ex(8'h62, 8'h90, 8'h00);
		$display("exclusive or test done");
	endtask
	// opcode outside the slice: refused, nothing changes
	task t_bad;
		@(negedge clk_sys);
		instr_valid = 1'b1;
		opcode = 8'ha5;
		@(negedge clk_sys);
		instr_valid = 1'b0;
		chk({6'h00, done_q, bad_op_q}, 8'h01);
		chk(acc_q, ea);
		$display("refusal test done");
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// hang guard, far above the expected run
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			close_out;
		end
	end
	initial begin
		repeat (10) @(negedge clk_sys);
		resetn = 1'b1;
		chk(acc_q, 8'h00);
		chk(port_latch_q, 8'hff);
		chk({5'h00, cy_q, half_borrow_q, signed_range_q}, 8'h00);
		t_subb;
		t_move;
		t_xor;
		t_bad;
		close_out;
	end
endmodule
